//--- hw/freewheel_and_gate_current_config.sv
`include "fw_gate_defines.svh"

// Notes on behaviour
// - Freewheel byte, bridge 1 at bit 7
// - Select 0 drives complementary with inverted PWM
// - Select 1 leaves complementary off, diode recirculates
// - Freewheel bits reset to zero, active freewheeling
// - Bridge 1 current byte sets source and sink
// - Upper nibble source code, resets all ones
// - Lower nibble sink code, resets all ones
// - Codes map monotonically to sixteen current steps
// - Low-current option selects reduced current table
// - Side bit picks drive MOSFET, freewheel other
// - PWM settings apply only in PWM mode
module freewheel_and_gate_current_config (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [3:0] pwmIn,
  output fw_gate_pkg::gate_cmd_t gateCmd,
  output fw_gate_pkg::gate_current_t bridge1Current
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] code_to_ua(input logic [3:0] code, input logic lowOpt);
    logic [15:0] normal [16];
    logic [15:0] reduced [16];
    normal = '{16'h01f4, 16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0, 16'h1388, 16'h1770,
               16'h1b58, 16'h1f40, 16'h2ee0, 16'h3e80, 16'h4e20, 16'h5dc0, 16'h7918,
               16'hbb80, 16'hf230};
    reduced = '{16'h0032, 16'h006e, 16'h00aa, 16'h00e6, 16'h0122, 16'h015e, 16'h019a,
                16'h0258, 16'h02d5, 16'h0352, 16'h03e8, 16'h04b0, 16'h0578, 16'h0640,
                16'h0708, 16'h08fc};
    return lowOpt ? reduced[code] : normal[code];
  endfunction : code_to_ua

  function automatic logic [2:0] bit_of_bridge(input int n);
    return 3'((`NUM_BRIDGES - 1) - n);
  endfunction : bit_of_bridge

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] stateA_reg;
  logic [7:0] stateB_reg;
  logic [7:0] pwmSourceA_reg;
  logic [7:0] pwmSourceB_reg;
  logic [7:0] driveSide_reg;
  logic [7:0] freewheel_reg;
  logic [7:0] gateCurrent1_reg;
  logic lowCurrent_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  fw_gate_pkg::gate_cmd_t gateCmd_reg;
  fw_gate_pkg::gate_cmd_t gateCmd_next;
  fw_gate_pkg::gate_current_t current_reg;
  fw_gate_pkg::gate_current_t current_next;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic request = read | write;
  wire logic [5:0] index = address[7:2];
  wire logic writeEn = write & ack_reg & byteenable[0];
  wire logic wrStateA = writeEn & (index == `IDX_BRIDGE_STATE_A);
  wire logic wrStateB = writeEn & (index == `IDX_BRIDGE_STATE_B);
  wire logic wrSourceA = writeEn & (index == `IDX_PWM_SOURCE_A);
  wire logic wrSourceB = writeEn & (index == `IDX_PWM_SOURCE_B);
  wire logic wrSide = writeEn & (index == `IDX_DRIVE_SIDE);
  wire logic wrFreewheel = writeEn & (index == `IDX_FREEWHEEL);
  wire logic wrCurrent1 = writeEn & (index == `IDX_GATE_CURRENT1);
  wire logic wrLowCurrent = writeEn & (index == `IDX_LOW_CURRENT);
  logic [7:0] readMux;

  always_comb begin
    case (index)
      `IDX_BRIDGE_STATE_A: readMux = stateA_reg;
      `IDX_BRIDGE_STATE_B: readMux = stateB_reg;
      `IDX_PWM_SOURCE_A: readMux = pwmSourceA_reg;
      `IDX_PWM_SOURCE_B: readMux = pwmSourceB_reg;
      `IDX_DRIVE_SIDE: readMux = driveSide_reg;
      `IDX_FREEWHEEL: readMux = freewheel_reg;
      `IDX_GATE_CURRENT1: readMux = gateCurrent1_reg;
      `IDX_LOW_CURRENT: readMux = {7'h00, lowCurrent_reg};
      `IDX_GATE_STATUS: readMux = gateCmd_reg.high | 8'h00;
      default: readMux = 8'h00;
    endcase
  end

  wire logic [31:0] readWord = (index == `IDX_GATE_STATUS) ?
                               {16'h0000, gateCmd_reg.high, gateCmd_reg.low} :
                               {24'h000000, readMux};

  assign waitrequest = request & ~ack_reg;
  assign readdata = readdata_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= request & ~ack_reg;
      if (read & ~ack_reg) begin
        readdata_reg <= readWord;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateA_reg <= `RST_BRIDGE_STATE;
      stateB_reg <= `RST_BRIDGE_STATE;
      pwmSourceA_reg <= `RST_PWM_SOURCE_A;
      pwmSourceB_reg <= `RST_PWM_SOURCE_B;
      driveSide_reg <= `RST_DRIVE_SIDE;
      freewheel_reg <= `RST_FREEWHEEL;
      gateCurrent1_reg <= `RST_GATE_CURRENT1;
      lowCurrent_reg <= `RST_LOW_CURRENT;
    end else begin
      if (wrStateA) stateA_reg <= writedata[7:0];
      if (wrStateB) stateB_reg <= writedata[7:0];
      if (wrSourceA) pwmSourceA_reg <= writedata[7:0];
      if (wrSourceB) pwmSourceB_reg <= writedata[7:0];
      if (wrSide) driveSide_reg <= writedata[7:0];
      if (wrFreewheel) freewheel_reg <= writedata[7:0];
      if (wrCurrent1) gateCurrent1_reg <= writedata[7:0];
      if (wrLowCurrent) lowCurrent_reg <= writedata[0];
    end
  end

  // ----------------------------------------
  // Gate command generation
  // ----------------------------------------
  wire logic [15:0] stateAll = {stateA_reg, stateB_reg};
  wire logic [15:0] sourceAll = {pwmSourceA_reg, pwmSourceB_reg};

  always_comb begin
    logic [1:0] sel;
    logic pwm;
    logic side;
    logic fw;
    sel = 2'h0;
    pwm = 1'b0;
    side = 1'b0;
    fw = 1'b0;
    gateCmd_next = '0;
    for (int n = 0; n < `NUM_BRIDGES; n++) begin
      sel = sourceAll[2 * bit_of_bridge(n) +: 2];
      pwm = pwmIn[sel];
      side = driveSide_reg[bit_of_bridge(n)];
      fw = freewheel_reg[bit_of_bridge(n)];
      case (fw_gate_pkg::bridge_mode_t'(stateAll[2 * bit_of_bridge(n) +: 2]))
        fw_gate_pkg::MODE_HIZ: begin
          gateCmd_next.high[bit_of_bridge(n)] = 1'b0;
          gateCmd_next.low[bit_of_bridge(n)] = 1'b0;
        end
        fw_gate_pkg::MODE_DRIVE_LOW: begin
          gateCmd_next.high[bit_of_bridge(n)] = 1'b0;
          gateCmd_next.low[bit_of_bridge(n)] = 1'b1;
        end
        fw_gate_pkg::MODE_DRIVE_HIGH: begin
          gateCmd_next.high[bit_of_bridge(n)] = 1'b1;
          gateCmd_next.low[bit_of_bridge(n)] = 1'b0;
        end
        fw_gate_pkg::MODE_PWM: begin
          gateCmd_next.high[bit_of_bridge(n)] = side ? (~pwm & ~fw) : pwm;
          gateCmd_next.low[bit_of_bridge(n)] = side ? pwm : (~pwm & ~fw);
        end
        default: begin
          gateCmd_next.high[bit_of_bridge(n)] = 1'b0;
          gateCmd_next.low[bit_of_bridge(n)] = 1'b0;
        end
      endcase
    end
  end

  assign current_next.sourceUa = code_to_ua(
    gateCurrent1_reg[`SOURCE_CODE_MSB:`SOURCE_CODE_LSB], lowCurrent_reg);
  assign current_next.sinkUa = code_to_ua(
    gateCurrent1_reg[`SINK_CODE_MSB:`SINK_CODE_LSB], lowCurrent_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gateCmd_reg <= '0;
      current_reg <= '0;
    end else begin
      gateCmd_reg <= gateCmd_next;
      current_reg <= current_next;
    end
  end

  assign gateCmd = gateCmd_reg;
  assign bridge1Current = current_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_freewheel_write: assert property (
    wrFreewheel |=> freewheel_reg == $past(writedata[7:0]))
    else $error("freewheel byte not stored");

  a_active_complement: assert property (
    (stateA_reg[7:6] == 2'h3) && !driveSide_reg[7] && !freewheel_reg[7]
      && $stable(stateA_reg) && $stable(freewheel_reg) && $stable(driveSide_reg)
      && $stable(pwmIn) |=> gateCmd.low[7] == ~gateCmd.high[7])
    else $error("active freewheel complement wrong");

  a_passive_off: assert property (
    (stateA_reg[5:4] == 2'h3) && !driveSide_reg[6] && freewheel_reg[6]
      |=> !gateCmd.low[6])
    else $error("passive freewheel drove complement");

  a_passive_high_off: assert property (
    (stateB_reg[7:6] == 2'h3) && driveSide_reg[3] && freewheel_reg[3]
      |=> !gateCmd.high[3])
    else $error("passive freewheel drove high side");

  a_active_low_side: assert property (
    (stateA_reg[1:0] == 2'h3) && driveSide_reg[4] && !freewheel_reg[4]
      |=> gateCmd.high[4] == ~gateCmd.low[4])
    else $error("active freewheel complement wrong on low-side drive");

  a_pwm_high_drive: assert property (
    (stateA_reg[7:6] == 2'h3) && !driveSide_reg[7]
      |=> gateCmd.high[7] == $past(pwmIn[pwmSourceA_reg[7:6]]))
    else $error("high-side drive does not follow PWM");

  a_pwm_low_drive: assert property (
    (stateB_reg[7:6] == 2'h3) && driveSide_reg[3]
      |=> gateCmd.low[3] == $past(pwmIn[pwmSourceB_reg[7:6]]))
    else $error("low-side drive does not follow PWM");

  a_no_overlap: assert property (
    (gateCmd.high & gateCmd.low) == 8'h00)
    else $error("both gates of a bridge pulled up");

  a_reset_freewheel: assert property (
    $rose(rst_n) |-> freewheel_reg == 8'h00)
    else $error("freewheel reset wrong");

  a_current_hold: assert property (
    !wrCurrent1 |=> $stable(gateCurrent1_reg))
    else $error("current byte changed without write");

  a_source_map: assert property (
    !lowCurrent_reg && gateCurrent1_reg[7:4] == 4'hf && $stable(gateCurrent1_reg)
      && $stable(lowCurrent_reg) |=> bridge1Current.sourceUa == 16'hf230)
    else $error("source top code wrong");

  a_sink_map: assert property (
    !lowCurrent_reg && gateCurrent1_reg[3:0] == 4'h0 && $stable(gateCurrent1_reg)
      && $stable(lowCurrent_reg) |=> bridge1Current.sinkUa == 16'h01f4)
    else $error("sink bottom code wrong");

  a_low_table: assert property (
    lowCurrent_reg && gateCurrent1_reg[7:4] == 4'hf && $stable(gateCurrent1_reg)
      && $stable(lowCurrent_reg) |=> bridge1Current.sourceUa == 16'h08fc)
    else $error("reduced table not used");

  a_hiz_mode: assert property (
    stateA_reg[7:6] == 2'h0 |=> !gateCmd.high[7] && !gateCmd.low[7])
    else $error("hi-z bridge driven");

  a_bus_answer: assert property (
    request && !ack_reg |=> !waitrequest || !request)
    else $error("bus answer late");

  a_mode_low_on: assert property (
    stateB_reg[3:2] == 2'h1 |=> !gateCmd.high[1] && gateCmd.low[1])
    else $error("drive-low bridge wrong");

  a_mode_high_on: assert property (
    stateB_reg[5:4] == 2'h2 |=> gateCmd.high[2] && !gateCmd.low[2])
    else $error("drive-high bridge wrong");

  a_hiz_ignores_fw: assert property (
    (stateB_reg[1:0] == 2'h0) && freewheel_reg[0]
      |=> !gateCmd.high[0] && !gateCmd.low[0])
    else $error("hi-z bridge driven with freewheel set");

  a_current_write: assert property (
    wrCurrent1 |=> gateCurrent1_reg == $past(writedata[7:0]))
    else $error("current byte not stored");

  a_code_order: assert property (
    gateCurrent1_reg[7:4] > gateCurrent1_reg[3:0]
      |=> bridge1Current.sourceUa > bridge1Current.sinkUa)
    else $error("current codes not monotonic");

  a_low_sink: assert property (
    lowCurrent_reg && gateCurrent1_reg[3:0] == 4'h0 && $stable(lowCurrent_reg)
      |=> bridge1Current.sinkUa == 16'h0032)
    else $error("reduced sink table not used");

  a_low_write: assert property (
    wrLowCurrent |=> lowCurrent_reg == $past(writedata[0]))
    else $error("low-current option not stored");

  a_masked_write: assert property (
    write && ack_reg && !byteenable[0] && index == `IDX_FREEWHEEL
      |=> $stable(freewheel_reg))
    else $error("masked write changed freewheel byte");

  a_freewheel_readback: assert property (
    read && !ack_reg && index == `IDX_FREEWHEEL
      |=> readdata == {24'h000000, $past(freewheel_reg)})
    else $error("freewheel readback wrong");

  a_current_readback: assert property (
    read && !ack_reg && index == `IDX_GATE_CURRENT1
      |=> readdata == {24'h000000, $past(gateCurrent1_reg)})
    else $error("current byte readback wrong");

  a_status_word: assert property (
    read && !ack_reg && index == `IDX_GATE_STATUS
      |=> readdata == {16'h0000, $past(gateCmd)})
    else $error("gate status readback wrong");

  a_reset_current: assert property (
    $rose(rst_n) |-> gateCurrent1_reg == `RST_GATE_CURRENT1 && !lowCurrent_reg)
    else $error("current byte reset wrong");

endmodule : freewheel_and_gate_current_config

//--- hw/fw_gate_defines.svh
`ifndef FW_GATE_DEFINES_SVH
`define FW_GATE_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_BRIDGE_STATE_A 6'h08
`define IDX_BRIDGE_STATE_B 6'h09
`define IDX_PWM_SOURCE_A 6'h0b
`define IDX_PWM_SOURCE_B 6'h0c
`define IDX_DRIVE_SIDE 6'h0d
`define IDX_FREEWHEEL 6'h0e
`define IDX_GATE_CURRENT1 6'h0f
`define IDX_LOW_CURRENT 6'h1a
`define IDX_GATE_STATUS 6'h1b

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BRIDGE_STATE 8'h00
`define RST_PWM_SOURCE_A 8'h05
`define RST_PWM_SOURCE_B 8'haf
`define RST_DRIVE_SIDE 8'h00
`define RST_FREEWHEEL 8'h00
`define RST_GATE_CURRENT1 8'hff
`define RST_LOW_CURRENT 1'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SOURCE_CODE_MSB 7
`define SOURCE_CODE_LSB 4
`define SINK_CODE_MSB 3
`define SINK_CODE_LSB 0
`define NUM_BRIDGES 8

`endif

//--- hw/fw_gate_pkg.sv
package fw_gate_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_HIZ,
    MODE_DRIVE_LOW,
    MODE_DRIVE_HIGH,
    MODE_PWM
  } bridge_mode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } gate_cmd_t;

  typedef struct packed {
    logic [15:0] sourceUa;
    logic [15:0] sinkUa;
  } gate_current_t;

endpackage : fw_gate_pkg

//--- tb/fw_host_model.sv
module fw_host_model (
  input wire logic clk,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // Bus cycles
  // ----------------
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
  end
  task automatic busWrite(input logic [5:0] idx, input logic [7:0] data, input logic [3:0] be);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, data};
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : busWrite
  task automatic busRead(input logic [5:0] idx, output logic [31:0] data);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    data = readdata;
    read <= 1'b0;
  endtask : busRead
endmodule : fw_host_model

//--- tb/freewheel_and_gate_current_config_bench.sv
module freewheel_and_gate_current_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] modeCfg = 16'hffe4;
  localparam logic [7:0] sideCfg = 8'h18;
  localparam logic [7:0] fwCfg = 8'h49;
  logic clk, rst_n, read, write, waitrequest, p, comp;
  logic [7:0] address, hiE, loE;
  logic [31:0] writedata, readdata, rd, expCur;
  logic [3:0] byteenable, pwmIn;
  logic [1:0] md;
  fw_gate_pkg::gate_cmd_t gateCmd;
  fw_gate_pkg::gate_current_t bridge1Current;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] normUa [16] = '{16'd500, 16'd1000, 16'd2000, 16'd3000, 16'd4000, 16'd5000,
    16'd6000, 16'd7000, 16'd8000, 16'd12000, 16'd16000, 16'd20000, 16'd24000, 16'd31000,
    16'd48000, 16'd62000};
  logic [15:0] lowUa [16] = '{16'd50, 16'd110, 16'd170, 16'd230, 16'd290, 16'd350, 16'd410,
    16'd600, 16'd725, 16'd850, 16'd1000, 16'd1200, 16'd1400, 16'd1600, 16'd1800, 16'd2300};
  freewheel_and_gate_current_config uut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .pwmIn(pwmIn), .gateCmd(gateCmd),
    .bridge1Current(bridge1Current));
  fw_host_model host (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  // ----------------
  // Helpers
  // ----------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
  // ----------------
  // Tests
  // ----------------
  initial begin
    rst_n = 1'b0;
    pwmIn = 4'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("resetCurrent", {16'd62000, 16'd62000}, bridge1Current);
    check("resetGates", 32'h0, {16'h0, gateCmd});
    host.busRead(6'h0e, rd);
    check("freewheelReset", 32'h0, rd);
    host.busRead(6'h0f, rd);
    check("currentReset", 32'hff, rd);
    host.busWrite(6'h0e, 8'ha5, 4'h1);
    host.busWrite(6'h0e, 8'h5a, 4'h0);
    host.busRead(6'h0e, rd);
    check("freewheelRw", 32'ha5, rd);
    host.busRead(6'h3f, rd);
    check("unmapped", 32'h0, rd);
    $display("test registers done");
    for (int lo = 0; lo < 2; lo++) begin
      host.busWrite(6'h1a, {7'h00, lo[0]}, 4'h1);
      for (int c = 0; c < 16; c++) begin
        host.busWrite(6'h0f, {c[3:0], ~c[3:0]}, 4'h1);
        repeat (2) @(posedge clk);
        expCur = lo[0] ? {lowUa[c], lowUa[15-c]} : {normUa[c], normUa[15-c]};
        check("current", expCur, bridge1Current);
      end
    end
    host.busRead(6'h0f, rd);
    check("currentRw", 32'hf0, rd);
    $display("test currents done");
    host.busWrite(6'h08, modeCfg[15:8], 4'h1);
    host.busWrite(6'h09, modeCfg[7:0], 4'h1);
    host.busWrite(6'h0d, sideCfg, 4'h1);
    host.busWrite(6'h0e, fwCfg, 4'h1);
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      pwmIn <= v[3:0];
      repeat (2) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        p = v[k/2];
        comp = fwCfg[7-k] ? 1'b0 : ~p;
        md = modeCfg[15-2*k -: 2];
        hiE[7-k] = (md == 2'b11) ? (sideCfg[7-k] ? comp : p) : (md == 2'b10);
        loE[7-k] = (md == 2'b11) ? (sideCfg[7-k] ? p : comp) : (md == 2'b01);
      end
      check("gates", {16'h0, hiE, loE}, {16'h0, gateCmd});
    end
    $display("test gates done");
    host.busRead(6'h1b, rd);
    check("status", {16'h0, hiE, loE}, rd);
    host.busWrite(6'h1b, 8'h00, 4'h1);
    host.busRead(6'h1b, rd);
    check("statusRo", {16'h0, hiE, loE}, rd);
    $display("test status done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("midCurrent", {16'd62000, 16'd62000}, bridge1Current);
    check("midGates", 32'h0, {16'h0, gateCmd});
    host.busRead(6'h0e, rd);
    check("midFreewheel", 32'h0, rd);
    host.busRead(6'h0f, rd);
    check("midCurrentByte", 32'hff, rd);
    $display("test reset done");
    conclude();
  end
endmodule : freewheel_and_gate_current_config_bench
